// ### src/pwdc_top.sv
// Operation
// - At each cycle end add the 4-bit dither increment into a 4-bit accumulator.
// - On accumulator overflow issue a one-step stretch of the chosen portion.
// - The target select field decides on-time or dead time gets the stretch.
// - Select 0 ramp B on, 1 ramps A+B on, 2 B dead, 3 A+B dead.
// - Dither increment is double-buffered and loads on the update condition.
// - Halt-fault at 1 with run-while-halted at 0: debug halt raises a fault and sets both trigger flags.
// - Halt-fault at 0: debug halt raises no fault.
// - Run-while-halted at 0: freeze and ignore events during break debug.
// - Run-while-halted at 1: keep running normally during break debug.
// - Captures are 12-bit read-only values seen as low and high bytes.
// - Capture A samples the counter on trigger A or software capture A.
// - Capture B samples the counter on trigger B or software capture B.
// - A capture starts from a software request or an incoming event.
// - Visible captures load from the first buffer only on update.
// - Presented capture blocks new data until software reads its high byte.
`timescale 1ns/1ps
`default_nettype none

module pwdc_top #(
	parameter int CNT_W = 12,
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [CNT_W-1:0] counter_i,
	input wire pwdc_pkg::pwdc_evt_s evt_i,
	input wire logic debug_halt_i,
	output logic timer_run_o,
	output logic dither_step_a_o,
	output logic dither_step_b_o,
	output logic dither_deadtime_o,
	output logic fault_o,
	output logic trig_flags_set_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pwdc_pkg::pwdc_bus_e bus_state_ff;
	logic [31:0] rdata_ff;
	logic [pwdc_pkg::SEL_W-1:0] dither_target_ff;
	logic [pwdc_pkg::DITHER_W-1:0] dither_val_ff;
	logic [pwdc_pkg::DITHER_W-1:0] dither_act_ff;
	logic [pwdc_pkg::DITHER_W-1:0] acc_ff;
	logic run_halted_ff;
	logic halt_fault_ff;
	logic fault_ff;
	logic trig_set_ff;
	logic step_a_ff;
	logic step_b_ff;
	logic run_ff;
	logic [CNT_W-1:0] buf_ff [2];
	logic [CNT_W-1:0] cap_ff [2];
	logic [1:0] pend_ff;
	logic [1:0] lock_ff;
	logic [pwdc_pkg::IRQ_W-1:0] irq_sts_ff;
	logic [pwdc_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [5:0] idx;
	logic acc_ok;
	logic wr_ok;
	logic rd_ok;
	logic halted;
	logic frozen;
	logic cyc_end;
	logic upd;
	logic ovf;
	logic [pwdc_pkg::DITHER_W:0] acc_sum;
	logic [1:0] trig;
	logic [1:0] sw_cap;
	logic [1:0] present;
	logic [1:0] hi_read;
	logic [pwdc_pkg::IRQ_W-1:0] irq_evt;
	logic [31:0] nxt_rdata;

	// Capture reset value, declared ahead of the capture process that reads it.
	localparam logic [CNT_W-1:0] RST_CAP = CNT_W'(pwdc_pkg::RST_CAPTURE);

	// Picks one byte of a capture value, zero-extended to the bus width.
	function automatic logic [31:0] cap_byte(input logic [CNT_W-1:0] v, input logic hi);
		logic [15:0] w;
		w = 16'(v);
		cap_byte = hi ? 32'(w[15:8]) : 32'(w[7:0]);
	endfunction

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// Every access is answered in the second clock-enabled cycle; the commit point is the
	// ACK state so write effects and read side effects happen exactly once.
	assign idx = avs_address_i[ADDR_W-1:2];
	assign acc_ok = (bus_state_ff == pwdc_pkg::BUS_ACK) && ce_i;
	assign wr_ok = acc_ok && avs_write_i && avs_byteenable_i[0];
	assign rd_ok = acc_ok && avs_read_i;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !acc_ok;
	assign avs_readdata_o = rdata_ff;

	// Bus state advances only while the clock enable is high.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_state_ff <= pwdc_pkg::BUS_IDLE;
		end else if (ce_i) begin
			case (bus_state_ff)
				pwdc_pkg::BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state_ff <= pwdc_pkg::BUS_ACK;
					end
				end
				pwdc_pkg::BUS_ACK: begin
					bus_state_ff <= pwdc_pkg::BUS_IDLE;
				end
				default: begin
					bus_state_ff <= pwdc_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Read mux; unmapped indices and reserved bits read as zero.
	always_comb begin
		nxt_rdata = pwdc_pkg::RD_UNMAPPED;
		case (idx)
			pwdc_pkg::IDX_DITHER_TARGET: nxt_rdata = 32'(dither_target_ff);
			pwdc_pkg::IDX_DITHER_INC: nxt_rdata = 32'(dither_val_ff);
			pwdc_pkg::IDX_DEBUG_CTRL: begin
				nxt_rdata[pwdc_pkg::BIT_RUN_HALTED] = run_halted_ff;
				nxt_rdata[pwdc_pkg::BIT_HALT_FAULT] = halt_fault_ff;
			end
			pwdc_pkg::IDX_CAP_A_LO: nxt_rdata = cap_byte(cap_ff[0], 1'b0);
			pwdc_pkg::IDX_CAP_A_HI: nxt_rdata = cap_byte(cap_ff[0], 1'b1);
			pwdc_pkg::IDX_CAP_B_LO: nxt_rdata = cap_byte(cap_ff[1], 1'b0);
			pwdc_pkg::IDX_CAP_B_HI: nxt_rdata = cap_byte(cap_ff[1], 1'b1);
			pwdc_pkg::IDX_IRQ_STATUS: nxt_rdata = 32'(irq_sts_ff);
			pwdc_pkg::IDX_IRQ_MASK: nxt_rdata = 32'(irq_mask_ff);
			default: nxt_rdata = pwdc_pkg::RD_UNMAPPED;
		endcase
	end

	// Read data is captured on entry to ACK and stands through it.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_ff <= pwdc_pkg::RD_UNMAPPED;
		end else if (ce_i && bus_state_ff == pwdc_pkg::BUS_IDLE && avs_read_i) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Writes to the increment land in the shadow copy only.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dither_target_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::SEL_W-1:0];
			dither_val_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::DITHER_W-1:0];
			run_halted_ff <= 1'b0;
			halt_fault_ff <= 1'b0;
			irq_mask_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::IRQ_W-1:0];
		end else if (wr_ok) begin
			case (idx)
				pwdc_pkg::IDX_DITHER_TARGET: begin
					dither_target_ff <= avs_writedata_i[pwdc_pkg::SEL_W-1:0];
				end
				pwdc_pkg::IDX_DITHER_INC: begin
					dither_val_ff <= avs_writedata_i[pwdc_pkg::DITHER_W-1:0];
				end
				pwdc_pkg::IDX_DEBUG_CTRL: begin
					run_halted_ff <= avs_writedata_i[pwdc_pkg::BIT_RUN_HALTED];
					halt_fault_ff <= avs_writedata_i[pwdc_pkg::BIT_HALT_FAULT];
				end
				pwdc_pkg::IDX_IRQ_MASK: begin
					irq_mask_ff <= avs_writedata_i[pwdc_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Debug halt
	// ----------------------------------------------------------------
	// While frozen the timer ignores its events; with the run bit set a
	// debug halt changes nothing.
	assign halted = debug_halt_i && !run_halted_ff;
	assign frozen = halted || !ce_i;
	assign cyc_end = evt_i.cycle_end && !frozen;
	assign upd = evt_i.update && !frozen;
	assign trig = {evt_i.trig_b, evt_i.trig_a} & {2{!frozen}};

	// Fault is a level for the whole halt; trigger flags pulse once on entry.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fault_ff <= 1'b0;
			trig_set_ff <= 1'b0;
			run_ff <= 1'b0;
		end else if (ce_i) begin
			fault_ff <= halted && halt_fault_ff;
			trig_set_ff <= halted && halt_fault_ff && !fault_ff;
			run_ff <= !halted;
		end
	end
	assign fault_o = fault_ff;
	assign trig_flags_set_o = trig_set_ff;
	assign timer_run_o = run_ff;

	// ----------------------------------------------------------------
	// Dither
	// ----------------------------------------------------------------
	assign acc_sum = {1'b0, acc_ff} + {1'b0, dither_act_ff};
	assign ovf = cyc_end && acc_sum[pwdc_pkg::DITHER_W];

	// Active increment follows the shadow only at an update, so a change
	// never lands half way through a dither sequence.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dither_act_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::DITHER_W-1:0];
		end else if (upd) begin
			dither_act_ff <= dither_val_ff;
		end
	end

	// Accumulator wraps; the carry out is the stretch request.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::DITHER_W-1:0];
		end else if (cyc_end) begin
			acc_ff <= acc_sum[pwdc_pkg::DITHER_W-1:0];
		end
	end

	// Ramp B always gets the step; ramp A only in the A+B encodings.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			step_a_ff <= 1'b0;
			step_b_ff <= 1'b0;
		end else if (ce_i) begin
			step_b_ff <= ovf;
			step_a_ff <= ovf && dither_target_ff[pwdc_pkg::SEL_BIT_BOTH];
		end
	end
	assign dither_step_a_o = step_a_ff;
	assign dither_step_b_o = step_b_ff;
	assign dither_deadtime_o = dither_target_ff[pwdc_pkg::SEL_BIT_DEAD];

	// ----------------------------------------------------------------
	// Capture channels
	// ----------------------------------------------------------------
	assign sw_cap[0] = wr_ok && idx == pwdc_pkg::IDX_SW_CAPTURE && avs_writedata_i[0];
	assign sw_cap[1] = wr_ok && idx == pwdc_pkg::IDX_SW_CAPTURE && avs_writedata_i[1];
	assign hi_read[0] = rd_ok && idx == pwdc_pkg::IDX_CAP_A_HI;
	assign hi_read[1] = rd_ok && idx == pwdc_pkg::IDX_CAP_B_HI;
	assign present = pend_ff & ~lock_ff & {2{upd}};

	// First stage samples the counter; second stage is loaded on update
	// and then held until the high byte is read. A new sample in the same
	// cycle as a transfer stays pending for the next update.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 2; i++) begin
				buf_ff[i] <= RST_CAP;
				cap_ff[i] <= RST_CAP;
			end
			pend_ff <= 2'b00;
			lock_ff <= 2'b00;
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				if (trig[i] || sw_cap[i]) begin
					buf_ff[i] <= counter_i;
					pend_ff[i] <= 1'b1;
				end else if (present[i]) begin
					pend_ff[i] <= 1'b0;
				end
				if (present[i]) begin
					cap_ff[i] <= buf_ff[i];
					lock_ff[i] <= 1'b1;
				end else if (hi_read[i]) begin
					lock_ff[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_evt = {trig_set_ff, present};

	// Set wins over a write-one clear landing in the same cycle.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_sts_ff <= pwdc_pkg::RST_BYTE[pwdc_pkg::IRQ_W-1:0];
		end else if (ce_i) begin
			if (wr_ok && idx == pwdc_pkg::IDX_IRQ_STATUS) begin
				irq_sts_ff <= (irq_sts_ff & ~avs_writedata_i[pwdc_pkg::IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_sts_ff <= irq_sts_ff | irq_evt;
			end
		end
	end
	assign irq_o = |(irq_sts_ff & irq_mask_ff);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_acc_add;
		cyc_end |=> acc_ff == 4'($past(acc_ff) + $past(dither_act_ff));
	endproperty
	a_acc_add: assert property (p_acc_add) else $error("accumulator sum wrong");

	property p_ovf_step;
		ovf ##1 ce_i |-> step_b_ff;
	endproperty
	a_ovf_step: assert property (p_ovf_step) else $error("overflow gave no step");

	property p_step_a_sel;
		step_a_ff |-> $past(dither_target_ff[pwdc_pkg::SEL_BIT_BOTH]) && step_b_ff;
	endproperty
	a_step_a_sel: assert property (p_step_a_sel) else $error("ramp A stepped off select");

	property p_dbuf;
		!upd && !cyc_end |=> $stable(dither_act_ff) && $stable(acc_ff);
	endproperty
	a_dbuf: assert property (p_dbuf) else $error("dither changed without event");

	property p_fault;
		ce_i && halted && halt_fault_ff ##1 ce_i |-> fault_o ##1 irq_sts_ff[pwdc_pkg::IRQ_FAULT];
	endproperty
	a_fault: assert property (p_fault) else $error("halt fault missing");

	property p_no_fault;
		ce_i && !halt_fault_ff |=> !fault_o && !trig_flags_set_o;
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("fault with control off");

	property p_capture;
		ce_i && trig[0] |=> buf_ff[0] == $past(counter_i) && pend_ff[0];
	endproperty
	a_capture: assert property (p_capture) else $error("capture A not sampled");

	property p_lock;
		lock_ff[1] && !hi_read[1] |=> $stable(cap_ff[1]) && lock_ff[1];
	endproperty
	a_lock: assert property (p_lock) else $error("locked capture changed");

	property p_bus_answer;
		bus_state_ff == pwdc_pkg::BUS_IDLE && (avs_read_i || avs_write_i) && ce_i ##1 ce_i
			|-> !avs_waitrequest_o;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule

`default_nettype wire

// ### src/pwdc_pkg.sv
package pwdc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_DITHER_TARGET = 6'h18;
	localparam logic [5:0] IDX_DITHER_INC = 6'h19;
	localparam logic [5:0] IDX_DEBUG_CTRL = 6'h1e;
	localparam logic [5:0] IDX_CAP_A_LO = 6'h22;
	localparam logic [5:0] IDX_CAP_A_HI = 6'h23;
	localparam logic [5:0] IDX_CAP_B_LO = 6'h24;
	localparam logic [5:0] IDX_CAP_B_HI = 6'h25;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
	localparam logic [5:0] IDX_SW_CAPTURE = 6'h32;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int DITHER_W = 4;
	localparam int SEL_W = 2;
	localparam int BIT_RUN_HALTED = 0;
	localparam int BIT_HALT_FAULT = 2;
	localparam int SEL_BIT_BOTH = 0;
	localparam int SEL_BIT_DEAD = 1;
	localparam int IRQ_W = 3;
	localparam int IRQ_CAP_A = 0;
	localparam int IRQ_CAP_B = 1;
	localparam int IRQ_FAULT = 2;
	localparam int BYTE_W = 8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [11:0] RST_CAPTURE = 12'h000;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} pwdc_bus_e;

	typedef struct packed {
		logic cycle_end;
		logic update;
		logic trig_a;
		logic trig_b;
	} pwdc_evt_s;

endpackage

// ### verification/pwm_timer_dither_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((ex) !== (gt)) begin fails++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end

module pwm_timer_dither_capture_bench;
	logic ref_clk_i;
	logic resetn_i;
	logic ce_i;
	logic [7:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [11:0] counter_i;
	pwdc_pkg::pwdc_evt_s evt_i;
	logic debug_halt_i;
	logic timer_run_o, dither_step_a_o, dither_step_b_o, dither_deadtime_o;
	logic fault_o, trig_flags_set_o, irq_o;
	int fails, tests_run, tf_cnt, tf0;
	logic [31:0] rd;
	logic [3:0] acc_m, inc_act, nxt;
	logic [1:0] sel_m;
	logic sa, sb;
	logic [11:0] c1, c2;
	logic [5:0] lo;
	logic [5:0] rst_idx [10] = '{6'h18, 6'h19, 6'h1e, 6'h22, 6'h23,
		6'h24, 6'h25, 6'h30, 6'h31, 6'h3f};

	pwdc_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.counter_i(counter_i), .evt_i(evt_i), .debug_halt_i(debug_halt_i),
		.timer_run_o(timer_run_o), .dither_step_a_o(dither_step_a_o),
		.dither_step_b_o(dither_step_b_o), .dither_deadtime_o(dither_deadtime_o),
		.fault_o(fault_o), .trig_flags_set_o(trig_flags_set_o), .irq_o(irq_o));

	// Free-running 100 MHz clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Counts trigger-flag pulses so a repeated pulse during one halt is caught.
	always @(posedge ref_clk_i) begin
		if (trig_flags_set_o === 1'b1) tf_cnt++;
	end

	task automatic close_out;
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One Avalon transfer; entered just after a rising edge, leaves one idle cycle.
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		input logic [3:0] be);
		int n;
		n = 0;
		avs_address_i <= {idx, 2'b00};
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= {24'h00_0000, wd};
		avs_byteenable_i <= be;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20) begin
			fails++;
			close_out();
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask

	task automatic rdchk(input string nm, input logic [5:0] idx, input logic [7:0] ex);
		bus(1'b0, idx, 8'h00, 4'h0);
		`CHK(nm, {24'h00_0000, ex}, rd)
	endtask

	// Drives one event pulse; the step outputs are sampled in the following cycle.
	task automatic pulse(input logic [3:0] v);
		evt_i <= pwdc_pkg::pwdc_evt_s'(v);
		@(posedge ref_clk_i);
		evt_i <= pwdc_pkg::pwdc_evt_s'(4'h0);
		#1;
		sa = dither_step_a_o;
		sb = dither_step_b_o;
		@(posedge ref_clk_i);
	endtask

	// Five-bit sum of accumulator and increment; bit 4 is the stretch carry.
	function automatic logic [4:0] acc_next(input logic [3:0] a, input logic [3:0] inc);
		return {1'b0, a} + {1'b0, inc};
	endfunction

	// One cycle end against the accumulator model; a frozen timer must not move.
	task automatic cyc(input logic frozen);
		logic [4:0] s;
		logic c;
		s = acc_next(acc_m, inc_act);
		c = s[4] & ~frozen;
		pulse(4'h8);
		`CHK("step_b", c, sb)
		`CHK("step_a", c & sel_m[0], sa)
		if (!frozen) acc_m = s[3:0];
	endtask

	task automatic halt_check(input logic [7:0] ctl, input logic run, input logic flt);
		wr(pwdc_pkg::IDX_DEBUG_CTRL, ctl);
		tf0 = tf_cnt;
		debug_halt_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		`CHK("timer_run", run, timer_run_o)
		`CHK("fault", flt, fault_o)
		cyc(~run);
		cyc(~run);
		`CHK("flag_pulses", flt ? 1 : 0, tf_cnt - tf0)
		debug_halt_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask

	initial begin
		#500000;
		fails++;
		close_out();
	end

	initial begin
		resetn_i = 1'b0;
		ce_i = 1'b1;
		avs_address_i = 8'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0000_0000;
		avs_byteenable_i = 4'h0;
		counter_i = 12'h000;
		evt_i = pwdc_pkg::pwdc_evt_s'(4'h0);
		debug_halt_i = 1'b0;
		fails = 0;
		tests_run = 0;
		tf_cnt = 0;
		acc_m = 4'h0;
		inc_act = 4'h0;
		void'($urandom(32'ha11f));
		repeat (8) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		// Reset values of every register, and an unmapped index.
		for (int i = 0; i < 10; i++) begin
			rdchk("reset", rst_idx[i], 8'h00);
		end
		`CHK("irq_reset", 1'b0, irq_o)
		wr(pwdc_pkg::IDX_DEBUG_CTRL, 8'h05);
		bus(1'b1, pwdc_pkg::IDX_DEBUG_CTRL, 8'h00, 4'h0);
		rdchk("dbg_rw", pwdc_pkg::IDX_DEBUG_CTRL, 8'h05);
		wr(pwdc_pkg::IDX_DEBUG_CTRL, 8'h00);
		wr(pwdc_pkg::IDX_CAP_A_LO, 8'hff);
		rdchk("cap_ro", pwdc_pkg::IDX_CAP_A_LO, 8'h00);
		$display("test registers done");
		// Dither over all four target encodings, with the shadow increment.
		for (int k = 0; k < 4; k++) begin
			sel_m = k[1:0];
			wr(pwdc_pkg::IDX_DITHER_TARGET, {6'h00, sel_m});
			nxt = 4'($urandom_range(15, 1));
			wr(pwdc_pkg::IDX_DITHER_INC, {4'h0, nxt});
			cyc(1'b0);
			cyc(1'b0);
			pulse(4'h4);
			inc_act = nxt;
			repeat (6) cyc(1'b0);
			`CHK("deadtime", sel_m[1], dither_deadtime_o)
		end
		// With the clock enable low a cycle end must neither step nor advance the sum.
		ce_i <= 1'b0;
		cyc(1'b1);
		ce_i <= 1'b1;
		$display("test dither done");
		// Capture A by trigger, B by software, then the lock on each.
		for (int ch = 0; ch < 2; ch++) begin
			lo = ch ? pwdc_pkg::IDX_CAP_B_LO : pwdc_pkg::IDX_CAP_A_LO;
			c1 = 12'($urandom);
			c2 = 12'($urandom);
			counter_i <= c1;
			if (ch == 0) pulse(4'h2);
			else wr(pwdc_pkg::IDX_SW_CAPTURE, 8'h02);
			counter_i <= 12'($urandom);
			rdchk("cap_pre_update", lo, 8'h00);
			pulse(4'h4);
			counter_i <= c2;
			if (ch == 0) wr(pwdc_pkg::IDX_SW_CAPTURE, 8'h01);
			else pulse(4'h1);
			pulse(4'h4);
			rdchk("cap_lo", lo, c1[7:0]);
			rdchk("cap_hi", lo + 6'h01, {4'h0, c1[11:8]});
			pulse(4'h4);
			rdchk("cap_lo2", lo, c2[7:0]);
			rdchk("cap_hi2", lo + 6'h01, {4'h0, c2[11:8]});
			rdchk("status", pwdc_pkg::IDX_IRQ_STATUS, ch ? 8'h03 : 8'h01);
		end
		`CHK("irq_masked", 1'b0, irq_o)
		wr(pwdc_pkg::IDX_IRQ_MASK, 8'h01);
		`CHK("irq_raised", 1'b1, irq_o)
		wr(pwdc_pkg::IDX_IRQ_STATUS, 8'h01);
		`CHK("irq_cleared", 1'b0, irq_o)
		rdchk("status_w1c", pwdc_pkg::IDX_IRQ_STATUS, 8'h02);
		wr(pwdc_pkg::IDX_IRQ_STATUS, 8'h07);
		$display("test capture done");
		// Debug halt under the three control settings.
		wr(pwdc_pkg::IDX_DITHER_INC, 8'h0f);
		pulse(4'h4);
		inc_act = 4'hf;
		halt_check(8'h04, 1'b0, 1'b1);
		counter_i <= 12'($urandom);
		rdchk("fault_status", pwdc_pkg::IDX_IRQ_STATUS, 8'h04);
		`CHK("fault_gone", 1'b0, fault_o)
		halt_check(8'h00, 1'b0, 1'b0);
		halt_check(8'h01, 1'b1, 1'b0);
		rdchk("cap_kept", pwdc_pkg::IDX_CAP_B_LO, c2[7:0]);
		$display("test debug done");
		close_out();
	end
endmodule

`default_nettype wire
